// ---- pkg/spisf_defines.vh ----
/*
  Offsets, field positions and reset values of the SPI status flag block.
  Assumes inclusion by its bare name from rtl/.
*/
`ifndef SPISF_DEFINES_VH
`define SPISF_DEFINES_VH

`define SPISF_STATUS_ADDR 8'hd3
`define SPISF_STATUS_RST 8'h02
`define SPISF_BUSY_BIT 4
`define SPISF_TX_END_BIT 3
`define SPISF_RX_OVR_BIT 2
`define SPISF_TX_EMPTY_BIT 1
`define SPISF_RX_FULL_BIT 0
`define SPISF_IRQ_EN_W 4
`define SPISF_FLAG_RST 1'h0
`define SPISF_TX_EMPTY_RST 1'h1

`endif

// ---- rtl/spisf_status_flags.v ----
/*
  Status and interrupt-source flag logic of a master-only SPI controller.
  Assumes the shift engine, divider and control registers share mclk_i and
  deliver one-cycle strobes; the SFR port is a synchronous read/write port.
*/
`timescale 1ns/1ps
`include "spisf_defines.vh"

// Event-set flag with its own clear strobe
module spisf_flag_cell #(
  // Value taken in reset
  parameter RESET_VAL = 1'h0
) (
  // Clock and reset
  input wire mclk_i,
  input wire rst_n_i,
  // Set and clear strobes
  input wire set_i,
  input wire clr_i,
  // Flag state
  output wire flag_o,
  output wire flag_next_o
);

  reg flag_reg;
  reg flag_next;

  // Set placed last so an event in the clear cycle survives
  always @* begin
    flag_next = flag_reg;
    if (clr_i) begin
      flag_next = 1'b0;
    end
    if (set_i) begin
      flag_next = 1'b1;
    end
  end

  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      flag_reg <= RESET_VAL;
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign flag_o = flag_reg;
  assign flag_next_o = flag_next;

endmodule // spisf_flag_cell

module spisf_status_flags (
  // Clock and reset
  input wire mclk_i,
  input wire rst_n_i,
  // SFR port
  input wire [7:0] sfr_addr_i,
  input wire sfr_rd_i,
  input wire sfr_wr_i,
  output reg [7:0] sfr_rdata_o,
  // Second control register interrupt enables
  input wire [`SPISF_IRQ_EN_W-1:0] irq_enable_i,
  // Shift engine strobes
  input wire xfer_start_i,
  input wire xfer_done_i,
  input wire rx_overrun_i,
  input wire tx_load_i,
  input wire rx_store_i,
  // Holding register accesses
  input wire tx_hold_wr_i,
  input wire rx_hold_rd_i,
  // Status and interrupt
  output reg busy_o,
  output reg [7:0] spi_status_o,
  output reg irq_o
);

  // Busy bit state
  reg busy_reg;
  reg busy_next;

  // Status, read path and request
  reg [7:0] status_next;
  reg [7:0] rdata_next;
  reg [3:0] irq_source;
  reg irq_next;
  wire status_rd;

  // Flag cells
  wire tx_end_source_flag;
  wire tx_end_source_flag_next;
  wire rx_overrun_source_flag;
  wire rx_overrun_source_flag_next;
  wire tx_empty_source_flag;
  wire tx_empty_source_flag_next;
  wire rx_full_source_flag;
  wire rx_full_source_flag_next;

  // Writes to the status address are decoded nowhere: read-only register
  assign status_rd = sfr_rd_i && (sfr_addr_i == `SPISF_STATUS_ADDR);

  // Transmission end, cleared by a status read
  spisf_flag_cell #(
    .RESET_VAL(`SPISF_FLAG_RST)
  ) u_tx_end_flag (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .set_i(xfer_done_i),
    .clr_i(status_rd),
    .flag_o(tx_end_source_flag),
    .flag_next_o(tx_end_source_flag_next)
  );

  // Receive overrun, cleared by a status read
  spisf_flag_cell #(
    .RESET_VAL(`SPISF_FLAG_RST)
  ) u_rx_overrun_flag (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .set_i(rx_overrun_i),
    .clr_i(status_rd),
    .flag_o(rx_overrun_source_flag),
    .flag_next_o(rx_overrun_source_flag_next)
  );

  // Transmit holding empty; a status read leaves it alone
  spisf_flag_cell #(
    .RESET_VAL(`SPISF_TX_EMPTY_RST)
  ) u_tx_empty_flag (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .set_i(tx_load_i),
    .clr_i(tx_hold_wr_i),
    .flag_o(tx_empty_source_flag),
    .flag_next_o(tx_empty_source_flag_next)
  );

  // Receive holding full; a status read leaves it alone
  spisf_flag_cell #(
    .RESET_VAL(`SPISF_FLAG_RST)
  ) u_rx_full_flag (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .set_i(rx_store_i),
    .clr_i(rx_hold_rd_i),
    .flag_o(rx_full_source_flag),
    .flag_next_o(rx_full_source_flag_next)
  );

  // Start placed last: a new byte in the done cycle keeps busy high
  always @* begin
    busy_next = busy_reg;
    if (xfer_done_i) begin
      busy_next = 1'b0;
    end
    if (xfer_start_i) begin
      busy_next = 1'b1;
    end
  end

  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      busy_reg <= 1'b0;
    end else begin
      busy_reg <= busy_next;
    end
  end

  // Reserved bits stay zero whatever is written
  always @* begin
    status_next = 8'h00;
    status_next[`SPISF_BUSY_BIT] = busy_next;
    status_next[`SPISF_TX_END_BIT] = tx_end_source_flag_next;
    status_next[`SPISF_RX_OVR_BIT] = rx_overrun_source_flag_next;
    status_next[`SPISF_TX_EMPTY_BIT] = tx_empty_source_flag_next;
    status_next[`SPISF_RX_FULL_BIT] = rx_full_source_flag_next;
  end

  // One level request for all sources; software reads status for the cause
  always @* begin
    irq_source = status_next[`SPISF_TX_END_BIT:`SPISF_RX_FULL_BIT] & irq_enable_i;
    irq_next = |irq_source;
  end

  // Read data shows the value before the read-clear takes effect
  always @* begin
    rdata_next = 8'h00;
    if (status_rd) begin
      rdata_next = spi_status_o;
    end
  end

  // Outputs registered so every pin comes straight from a flop
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      busy_o <= 1'b0;
      spi_status_o <= `SPISF_STATUS_RST;
      sfr_rdata_o <= 8'h00;
      irq_o <= 1'b0;
    end else begin
      busy_o <= busy_next;
      spi_status_o <= status_next;
      sfr_rdata_o <= rdata_next;
      irq_o <= irq_next;
    end
  end

endmodule // spisf_status_flags

// ---- tb/spisf_sva_assertions.sv ----
/* Checker on the status flag ports.
   Assumes one clock, synchronous active-low reset. */
`timescale 1ns/1ps
module spisf_sva(input wire mclk_i,rst_n_i,sfr_rd_i,xfer_start_i,xfer_done_i,rx_overrun_i,
  tx_load_i,rx_store_i,tx_hold_wr_i,rx_hold_rd_i,busy_o,irq_o,
  input wire [7:0] sfr_addr_i,sfr_rdata_o,spi_status_o,input wire [3:0] irq_enable_i);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  wire rd = sfr_rd_i && sfr_addr_i == 8'hd3;
  busy_set_a: assert property (xfer_start_i |=> busy_o) else $error("busy low");
  busy_clr_a: assert property (xfer_done_i && !xfer_start_i |=> !busy_o) else $error("busy");
  end_set_a: assert property (xfer_done_i |=> spi_status_o[3]) else $error("end");
  end_clr_a: assert property (rd && !xfer_done_i |=> !spi_status_o[3]) else $error("e");
  ovr_clr_a: assert property (rd && !rx_overrun_i |=> !spi_status_o[2]) else $error("o");
  empty_set_a: assert property (tx_load_i |=> spi_status_o[1]) else $error("empty");
  empty_clr_a: assert property (tx_hold_wr_i && !tx_load_i |=>
    !spi_status_o[1]) else $error("empty kept");
  read_keep_a: assert property (rd && !tx_hold_wr_i && !rx_hold_rd_i |=>
    ($past(spi_status_o[1:0]) & ~spi_status_o[1:0]) == 2'h0) else $error("kept");
  full_clr_a: assert property (rx_hold_rd_i && !rx_store_i |=>
    !spi_status_o[0]) else $error("full kept");
  rsv_zero_a: assert property (spi_status_o[7:5] == 3'h0) else $error("reserved");
  ovr_set_a: assert property (rx_overrun_i |=> spi_status_o[2]) else $error("overrun");
  full_set_a: assert property (rx_store_i |=> spi_status_o[0]) else $error("full");
  busy_bit_a: assert property (busy_o == spi_status_o[4]) else $error("busy bit");
  rdata_idle_a: assert property (!rd |=> sfr_rdata_o == 8'h00) else $error("rdata idle");
  rdata_a: assert property (rd |=>
    sfr_rdata_o == $past(spi_status_o)) else $error("rdata");
  irq_a: assert property ($past(rst_n_i) |->
    irq_o == |(spi_status_o[3:0] & $past(irq_enable_i))) else $error("irq");
  cover property (rd && spi_status_o[3]);
  cover property (irq_o);
  cover property (xfer_start_i && xfer_done_i);
endmodule // spisf_sva
bind spisf_status_flags spisf_sva u_sva(.mclk_i(mclk_i), .rst_n_i(rst_n_i), .sfr_rd_i(sfr_rd_i),
  .xfer_start_i(xfer_start_i), .xfer_done_i(xfer_done_i), .rx_overrun_i(rx_overrun_i),
  .tx_load_i(tx_load_i), .rx_store_i(rx_store_i), .tx_hold_wr_i(tx_hold_wr_i),
  .rx_hold_rd_i(rx_hold_rd_i), .busy_o(busy_o), .irq_o(irq_o), .sfr_addr_i(sfr_addr_i),
  .sfr_rdata_o(sfr_rdata_o), .spi_status_o(spi_status_o), .irq_enable_i(irq_enable_i));

// ---- tb/tb_spi_status_flag_logic.sv ----
/* Bench for the status flags.
   Assumes the flag block drives registered outputs. */
`timescale 1ns/1ps
module tb_spi_status_flag_logic;
  reg mclk_i = 0, rst_n_i = 0, rd = 0, wr = 0;
  reg [6:0] ev = 0;
  reg [3:0] en = 0;
  reg [7:0] ad = 8'hd3;
  wire [7:0] rdata, st;
  wire busy, irq;
  integer error_cnt = 0, n_checks = 0, cyc = 0;
  spisf_status_flags DUT(.mclk_i(mclk_i), .rst_n_i(rst_n_i), .sfr_addr_i(ad), .sfr_rd_i(rd),
    .sfr_wr_i(wr), .sfr_rdata_o(rdata), .irq_enable_i(en), .xfer_start_i(ev[6]),
    .xfer_done_i(ev[5]), .rx_overrun_i(ev[4]), .tx_load_i(ev[3]), .rx_store_i(ev[2]),
    .tx_hold_wr_i(ev[1]), .rx_hold_rd_i(ev[0]), .busy_o(busy), .spi_status_o(st), .irq_o(irq));
  initial forever #12.5 mclk_i = ~mclk_i;
  task complete_run; begin
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  end endtask
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 400) begin
      error_cnt = error_cnt + 1;
      complete_run;
    end
  end
  task chk(input [7:0] got, input [7:0] exp); begin
    n_checks = n_checks + 1;
    if (got !== exp) begin
      error_cnt = error_cnt + 1;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  end endtask
  // Strobes one cycle wide, launched and dropped at falling edges
  task op(input [6:0] e, input r); begin
    @(negedge mclk_i);
    ev = e;
    rd = r;
    @(negedge mclk_i);
    ev = 0;
    rd = 0;
  end endtask
  initial begin
    repeat (16) @(negedge mclk_i);
    rst_n_i = 1;
    chk(st, 8'h02);
    chk({busy, irq}, 8'h00);
    en = 4'hf;
    op(7'h40, 0);
    chk(busy, 1);
    op(7'h60, 0);
    chk(busy, 1);
    op(7'h20, 0);
    chk(st, 8'h0a);
    chk(irq, 1);
    op(7'h12, 1);
    chk(rdata, 8'h0a);
    chk(st, 8'h04);
    op(7'h04, 1);
    chk(st, 8'h01);
    op(7'h00, 1);
    chk(st, 8'h01);
    en = 4'h2;
    op(7'h00, 0);
    chk(irq, 0);
    op(7'h05, 0);
    chk(st, 8'h01);
    op(7'h01, 0);
    chk(st, 8'h00);
    op(7'h0a, 0);
    chk(st, 8'h02);
    wr = 1;
    op(7'h00, 0);
    chk(st, 8'h02);
    wr = 0;
    ad = 8'h55;
    op(7'h20, 1);
    chk(st, 8'h0a);
    chk(rdata, 8'h00);
    chk(irq, 1);
    $display("flag sequence done");
    // Mid-run reset: events and a read while held must change nothing
    ad = 8'hd3;
    rst_n_i = 0;
    op(7'h20, 1);
    chk(st, 8'h02);
    chk({busy, irq}, 8'h00);
    chk(rdata, 8'h00);
    rst_n_i = 1;
    op(7'h00, 1);
    chk(rdata, 8'h02);
    $display("reset test done");
    complete_run;
  end
endmodule // tb_spi_status_flag_logic
